// File: rtl/analog_monitor_sequencer.sv
// Round-robin analog monitoring sequencer with value and limit registers
//
// Functional notes
// - Completed local temperature average is written to register 1Fh.
// - Temperatures are signed 8-bit two's complement, one degree per count.
// - Config bit 3 low: pin pair is second diode; high: analog inputs.
// - Remote diode results stored as 8-bit two's complement too.
// - A remote temperature measurement lasts nominally 2.13 ms.
// - Monitoring starts when bit 0 is one and clear bit 2 zero.
// - Interrupt output is driven only while enable bit 1 is one.
// - Channels convert in turn, remote one first, local temperature last.
// - Each finished channel updates its value register without software.
// - Passes repeat until bit 0 is written zero, then monitoring stops.
// - Pin pair converted as both analog inputs and diode every pass.
// - Analog config: pair voltages go to 27h and 29h, temperature dropped.
// - Diode config: second remote temperature goes to 29h, 27h untouched.
// - Conversion takes 711 us for voltages and local, 2.13 ms remote.
// - Stored reading is the average of sixteen conversions, except on the battery channel.
// - Conversions are timed from an internal 22.5 kHz tick.
// - Voltage readings outside the high/low window raise an interrupt.
// - Temperature hot limit sets, low limit clears, giving hysteresis.
// - Battery channel converts once per pass without averaging.
`timescale 1ns/1ps
`default_nettype none

module analog_monitor_sequencer #(
  parameter int TICK_DIVIDE = monitor_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] adc_data,
  output logic [4:0] adc_channel,
  output logic adc_start,
  output logic busy,
  output logic int_n
);
  import monitor_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] adc_meta_q;
  logic [7:0] adc_sync_q;

  seq_state_type state_q;
  seq_state_type state_d;
  logic [10:0] tick_div_q;
  logic [10:0] tick_div_d;
  logic [5:0] tick_count_q;
  logic [5:0] tick_count_d;
  logic [3:0] conv_count_q;
  logic [3:0] conv_count_d;
  logic [4:0] channel_q;
  logic [4:0] channel_d;
  logic adc_start_q;
  logic adc_start_d;
  logic busy_q;
  logic busy_d;

  logic [7:0] config_q;
  logic [7:0] config_d;
  logic [7:0] value_q [CH_COUNT];
  logic [7:0] value_d [CH_COUNT];
  logic [7:0] high_q [CH_COUNT];
  logic [7:0] high_d [CH_COUNT];
  logic [7:0] low_q [CH_COUNT];
  logic [7:0] low_d [CH_COUNT];
  logic [7:0] shared_pin_q;
  logic [7:0] shared_pin_d;
  logic [7:0] second_remote_q;
  logic [7:0] second_remote_d;
  logic [CH_COUNT-1:0] status_q;
  logic [CH_COUNT-1:0] status_d;
  logic [CH_COUNT-1:0] hot_q;
  logic [CH_COUNT-1:0] hot_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic int_n_q;
  logic int_n_d;

  // ----------------------------------------------------------------
  // Channel attributes and helper signals
  // ----------------------------------------------------------------
  logic is_remote;
  logic is_temp;
  logic is_single;
  logic pair_ain;
  logic run;
  logic tick;
  logic [5:0] conv_len;
  logic sample_now;
  logic avg_clear;
  logic [7:0] average;
  logic above;
  logic below;
  logic keep;

  // Per-channel properties of the slot being converted
  always_comb begin
    is_remote = (channel_q == CH_REMOTE1) || (channel_q == CH_REMOTE2);
    is_temp = is_remote || (channel_q == CH_LOCAL);
    is_single = channel_q == CH_VBAT;
    pair_ain = config_q[CFG_PAIR_AIN_BIT];
    run = config_q[CFG_START_BIT];
    conv_len = is_remote ? REMOTE_CONV_TICKS : LOCAL_CONV_TICKS;
    tick = tick_div_q == 11'(TICK_DIVIDE - 1);
    sample_now = (state_q == SEQ_CONVERT) && tick && (tick_count_q == 6'(conv_len - 6'h01));
    avg_clear = state_q != SEQ_CONVERT;
    // Pair readings that do not belong to the selected configuration are dropped
    keep = 1'b1;
    if (channel_q == CH_REMOTE2) begin
      keep = !pair_ain;
    end else if ((channel_q == CH_GENERAL_ANALOG_INPUT_EIGHT) || (channel_q == CH_GENERAL_ANALOG_INPUT_NINE)) begin
      keep = pair_ain;
    end
  end

  // ----------------------------------------------------------------
  // Converter data synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_meta_q <= 8'h00;
      adc_sync_q <= 8'h00;
    end else begin
      adc_meta_q <= adc_data;
      adc_sync_q <= adc_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Averaging and limit comparison
  // ----------------------------------------------------------------
  sample_averager u_averager (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(avg_clear),
    .add(sample_now),
    .signed_mode(is_temp),
    .single_shot(is_single),
    .sample(adc_sync_q),
    .average(average)
  );

  limit_compare u_compare (
    .value(average),
    .high_limit(high_q[channel_q]),
    .low_limit(low_q[channel_q]),
    .signed_mode(is_temp),
    .above(above),
    .below(below)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    tick_div_d = tick ? 11'h000 : 11'(tick_div_q + 11'h001);
    tick_count_d = tick_count_q;
    conv_count_d = conv_count_q;
    channel_d = channel_q;
    adc_start_d = 1'b0;
    busy_d = state_q != SEQ_IDLE;
    case (state_q)
      SEQ_IDLE: begin
        tick_div_d = 11'h000;
        // Start needs the clear bit low as well
        if (run && !config_q[CFG_INT_CLR_BIT]) begin
          state_d = SEQ_CONVERT;
          channel_d = CH_REMOTE1;
          tick_count_d = 6'h00;
          conv_count_d = 4'h0;
          adc_start_d = 1'b1;
        end
      end
      SEQ_CONVERT: begin
        if (tick) begin
          tick_count_d = 6'(tick_count_q + 6'h01);
        end
        if (sample_now) begin
          tick_count_d = 6'h00;
          // Sixteen conversions per reading, one for the battery channel
          if (is_single || (conv_count_q == AVG_LAST)) begin
            state_d = SEQ_STORE;
          end else begin
            conv_count_d = 4'(conv_count_q + 4'h1);
            adc_start_d = 1'b1;
          end
        end
      end
      SEQ_STORE: begin
        state_d = SEQ_CONVERT;
        tick_count_d = 6'h00;
        conv_count_d = 4'h0;
        adc_start_d = 1'b1;
        if (channel_q == CH_LOCAL) begin
          channel_d = CH_REMOTE1;
        end else begin
          channel_d = 5'(channel_q + 5'h01);
        end
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
    // Clearing the start bit halts monitoring at once
    if (!run) begin
      state_d = SEQ_IDLE;
      adc_start_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SEQ_IDLE;
      tick_div_q <= 11'h000;
      tick_count_q <= 6'h00;
      conv_count_q <= 4'h0;
      channel_q <= CH_REMOTE1;
      adc_start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tick_div_q <= tick_div_d;
      tick_count_q <= tick_count_d;
      conv_count_q <= conv_count_d;
      channel_q <= channel_d;
      adc_start_q <= adc_start_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file next state
  // ----------------------------------------------------------------
  always_comb begin
    config_d = config_q;
    value_d = value_q;
    high_d = high_q;
    low_d = low_q;
    shared_pin_d = shared_pin_q;
    second_remote_d = second_remote_q;
    hot_d = hot_q;
    status_d = status_q;
    rdata_d = 8'h00;
    // Software writes
    if (reg_write) begin
      if (reg_addr == ADDR_CONFIG) begin
        config_d = reg_wdata;
      end
      for (int i = 0; i < CH_COUNT; i++) begin
        if (reg_addr == 8'(ADDR_HIGH_BASE + 8'(i))) begin
          high_d[i] = reg_wdata;
        end
        if (reg_addr == 8'(ADDR_LOW_BASE + 8'(i))) begin
          low_d[i] = reg_wdata;
        end
      end
    end
    // Clear bit held high empties the limit flags
    if (config_q[CFG_INT_CLR_BIT]) begin
      status_d = '0;
    end
    // Completed reading lands in its value register; a new event wins over clear
    if (state_q == SEQ_STORE) begin
      value_d[channel_q] = average;
      if (keep) begin
        if (channel_q == CH_GENERAL_ANALOG_INPUT_EIGHT) begin
          shared_pin_d = average;
        end else if ((channel_q == CH_GENERAL_ANALOG_INPUT_NINE) || (channel_q == CH_REMOTE2)) begin
          second_remote_d = average;
        end
        if (is_temp) begin
          // Hot limit sets, falling under the low limit clears
          if (above) begin
            hot_d[channel_q] = 1'b1;
          end else if (below) begin
            hot_d[channel_q] = 1'b0;
          end
          if (hot_d[channel_q]) begin
            status_d[channel_q] = 1'b1;
          end
        end else if (above || below) begin
          status_d[channel_q] = 1'b1;
        end
      end
    end
    // Read data for the current address
    if (reg_addr == ADDR_CONFIG) begin
      rdata_d = config_q;
    end else if (reg_addr == ADDR_LOCAL_TEMP) begin
      rdata_d = value_q[CH_LOCAL];
    end else if (reg_addr == ADDR_SHARED_PIN) begin
      rdata_d = shared_pin_q;
    end else if (reg_addr == ADDR_SECOND_REMOTE) begin
      rdata_d = second_remote_q;
    end else if (reg_addr == ADDR_STATUS_BASE) begin
      rdata_d = status_q[7:0];
    end else if (reg_addr == 8'(ADDR_STATUS_BASE + 8'h01)) begin
      rdata_d = status_q[15:8];
    end else if (reg_addr == 8'(ADDR_STATUS_BASE + 8'h02)) begin
      rdata_d = {3'h0, status_q[20:16]};
    end else begin
      for (int i = 0; i < CH_COUNT; i++) begin
        if (reg_addr == 8'(ADDR_VALUE_BASE + 8'(i))) begin
          rdata_d = value_q[i];
        end
        if (reg_addr == 8'(ADDR_HIGH_BASE + 8'(i))) begin
          rdata_d = high_q[i];
        end
        if (reg_addr == 8'(ADDR_LOW_BASE + 8'(i))) begin
          rdata_d = low_q[i];
        end
      end
    end
    // Interrupt driven only while enabled
    int_n_d = !(config_q[CFG_INT_EN_BIT] && (|status_q));
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= CONFIG_RESET;
      for (int i = 0; i < CH_COUNT; i++) begin
        value_q[i] <= VALUE_RESET;
        high_q[i] <= HIGH_RESET;
        low_q[i] <= LOW_RESET;
      end
      shared_pin_q <= VALUE_RESET;
      second_remote_q <= VALUE_RESET;
      hot_q <= '0;
      status_q <= '0;
      rdata_q <= 8'h00;
      int_n_q <= 1'b1;
    end else begin
      config_q <= config_d;
      value_q <= value_d;
      high_q <= high_d;
      low_q <= low_d;
      shared_pin_q <= shared_pin_d;
      second_remote_q <= second_remote_d;
      hot_q <= hot_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      int_n_q <= int_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign adc_channel = channel_q;
  assign adc_start = adc_start_q;
  assign busy = busy_q;
  assign int_n = int_n_q;

endmodule : analog_monitor_sequencer
`default_nettype wire

// File: rtl/monitor_pkg.sv
// Constants shared by the analog monitoring sequencer and its helpers
package monitor_pkg;

  // ----------------------------------------------------------------
  // Clocking and conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int INT_CLK_HZ = 22_500;
  localparam int TICK_CYCLES = CLK_HZ / INT_CLK_HZ;
  localparam int INT_PERIOD_NS = 1_000_000_000 / INT_CLK_HZ;
  localparam int LOCAL_CONV_NS = 711_000;
  localparam int REMOTE_CONV_NS = 2_130_000;
  localparam logic [5:0] LOCAL_CONV_TICKS =
    6'((LOCAL_CONV_NS + INT_PERIOD_NS - 1) / INT_PERIOD_NS);
  localparam logic [5:0] REMOTE_CONV_TICKS =
    6'((REMOTE_CONV_NS + INT_PERIOD_NS - 1) / INT_PERIOD_NS);
  localparam logic [3:0] AVG_LAST = 4'hF;

  // ----------------------------------------------------------------
  // Channel slots in conversion order
  // ----------------------------------------------------------------
  localparam int CH_COUNT = 21;
  localparam logic [4:0] CH_REMOTE1 = 5'h00;
  localparam logic [4:0] CH_REMOTE2 = 5'h01;
  localparam logic [4:0] CH_GENERAL_ANALOG_INPUT_EIGHT = 5'h0A;
  localparam logic [4:0] CH_GENERAL_ANALOG_INPUT_NINE = 5'h0B;
  localparam logic [4:0] CH_VBAT = 5'h13;
  localparam logic [4:0] CH_LOCAL = 5'h14;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h1F;
  localparam logic [7:0] ADDR_SHARED_PIN = 8'h27;
  localparam logic [7:0] ADDR_SECOND_REMOTE = 8'h29;
  localparam logic [7:0] ADDR_VALUE_BASE = 8'h60;
  localparam logic [7:0] ADDR_HIGH_BASE = 8'h80;
  localparam logic [7:0] ADDR_LOW_BASE = 8'hA0;
  localparam logic [7:0] ADDR_STATUS_BASE = 8'hC0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'hFF;
  localparam logic [7:0] LOW_RESET = 8'h00;
  localparam int CFG_START_BIT = 0;
  localparam int CFG_INT_EN_BIT = 1;
  localparam int CFG_INT_CLR_BIT = 2;
  localparam int CFG_PAIR_AIN_BIT = 3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CONVERT,
    SEQ_STORE
  } seq_state_type;

endpackage : monitor_pkg

// File: rtl/sample_averager.sv
// Accumulates conversion samples and yields their sixteen-fold average
`timescale 1ns/1ps
`default_nettype none

module sample_averager (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic add,
  input wire logic signed_mode,
  input wire logic single_shot,
  input wire logic [7:0] sample,
  output logic [7:0] average
);
  import monitor_pkg::*;

  logic [11:0] sum_q;
  logic [11:0] sum_d;
  logic [11:0] extended;

  // Sign or zero extension, then running sum
  always_comb begin
    extended = signed_mode ? {{4{sample[7]}}, sample} : {4'h0, sample};
    sum_d = sum_q;
    if (clear) begin
      sum_d = 12'h000;
    end else if (add) begin
      sum_d = 12'(sum_q + extended);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sum_q <= 12'h000;
    end else begin
      sum_q <= sum_d;
    end
  end

  // Divide by sixteen; a single sample passes straight through
  assign average = single_shot ? sum_q[7:0] : sum_q[11:4];

endmodule : sample_averager
`default_nettype wire

// File: rtl/limit_compare.sv
// Window comparison of a reading against its high and low limits
`timescale 1ns/1ps
`default_nettype none

module limit_compare (
  input wire logic [7:0] value,
  input wire logic [7:0] high_limit,
  input wire logic [7:0] low_limit,
  input wire logic signed_mode,
  output logic above,
  output logic below
);
  import monitor_pkg::*;

  // Flipping the sign bit turns a signed compare into an unsigned one
  logic [7:0] v_key;
  logic [7:0] h_key;
  logic [7:0] l_key;

  always_comb begin
    v_key = {value[7] ^ signed_mode, value[6:0]};
    h_key = {high_limit[7] ^ signed_mode, high_limit[6:0]};
    l_key = {low_limit[7] ^ signed_mode, low_limit[6:0]};
    above = v_key > h_key;
    below = v_key < l_key;
  end

endmodule : limit_compare
`default_nettype wire

// File: testbench/analog_monitor_sequencer_asserts.sv
// Port checker for the analog monitoring sequencer
`timescale 1ns/1ps
`default_nettype none

module analog_monitor_sequencer_asserts
  import monitor_pkg::*;
#(
  parameter int TICK_DIVIDE = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] adc_data,
  input wire logic [4:0] adc_channel,
  input wire logic adc_start,
  input wire logic busy,
  input wire logic int_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic cfg_wr;
  logic int_en_q, int_en_d;
  logic [15:0] gap_q, gap_d;
  logic [4:0] last_q, last_d;
  int lo_gap;
  int hi_gap;

  // Interrupt enable copy and cycles since the last conversion start
  always_comb begin
    cfg_wr = reg_write && (reg_addr == ADDR_CONFIG);
    int_en_d = cfg_wr ? reg_wdata[CFG_INT_EN_BIT] : int_en_q;
    gap_d = adc_start ? 16'h0001 : (&gap_q ? gap_q : gap_q + 16'h0001);
    last_d = adc_start ? adc_channel : last_q;
    lo_gap = ((adc_channel <= CH_REMOTE2) ? 47 : 15) * TICK_DIVIDE;
    hi_gap = ((adc_channel <= CH_REMOTE2) ? 49 : 17) * TICK_DIVIDE + 2;
  end

  // Registers of the helper state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_en_q <= 1'b0;
      gap_q <= 16'hFFFF;
      last_q <= 5'h1F;
    end else begin
      int_en_q <= int_en_d;
      gap_q <= gap_d;
      last_q <= last_d;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence start_req;
    cfg_wr && reg_wdata[CFG_START_BIT] && !reg_wdata[CFG_INT_CLR_BIT] && !busy;
  endsequence
  sequence stop_req;
    cfg_wr && !reg_wdata[CFG_START_BIT];
  endsequence

  start_remote_a: assert property (
    start_req |-> ##[1:4] (adc_start && adc_channel == CH_REMOTE1))
    else $error("monitoring did not start on remote one");
  stop_quiet_a: assert property (
    stop_req |-> ##4 (!busy && !adc_start) [*4])
    else $error("sequencer still running after stop");
  start_pulse_a: assert property (
    adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  channel_order_a: assert property (
    (busy && $past(busy) && $changed(adc_channel)) |->
      (adc_channel == $past(adc_channel) + 5'h01) ||
      ($past(adc_channel) == CH_LOCAL && adc_channel == CH_REMOTE1))
    else $error("channel order broken");
  channel_range_a: assert property (
    busy |-> adc_channel <= CH_LOCAL)
    else $error("channel beyond local temperature");
  int_gate_a: assert property (
    !int_n |-> (int_en_q || $past(int_en_q)))
    else $error("interrupt driven while disabled");
  int_release_a: assert property (
    (cfg_wr && !reg_wdata[CFG_INT_EN_BIT]) |-> ##3 int_n [*2])
    else $error("interrupt not released");
  reset_quiet_a: assert property (
    $rose(reset_n) |-> (!busy && !adc_start && int_n))
    else $error("outputs not idle after reset");
  conv_spacing_a: assert property (
    (adc_start && adc_channel == last_q) |-> (gap_q >= lo_gap && gap_q <= hi_gap))
    else $error("conversion length wrong");
endmodule : analog_monitor_sequencer_asserts

bind analog_monitor_sequencer analog_monitor_sequencer_asserts #(
  .TICK_DIVIDE(TICK_DIVIDE)
) checker_i (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
  .adc_data(adc_data), .adc_channel(adc_channel), .adc_start(adc_start),
  .busy(busy), .int_n(int_n)
);

`default_nettype wire

// File: testbench/adc_sample_model.sv
// Behavioural converter front end giving ramp samples per channel
`timescale 1ns/1ps
`default_nettype none

module adc_sample_model
  import monitor_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] adc_channel,
  input wire logic adc_start,
  input wire logic [7:0] temp_base,
  input wire logic [7:0] volt_base,
  output logic [7:0] adc_data
);
  logic [4:0] last_q;
  logic [7:0] step_q;
  logic [7:0] step;

  // Ramp position of the next sample; back to zero on a new channel
  always_comb begin
    step = (adc_channel == last_q) ? 8'(step_q + 8'h01) : 8'h00;
  end

  // New sample per start; the ramp restarts when the channel moves on
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_q <= 5'h1F;
      step_q <= 8'h00;
      adc_data <= 8'hA5;
    end else if (adc_start) begin
      step_q <= step;
      last_q <= adc_channel;
      if (adc_channel <= CH_REMOTE2 || adc_channel == CH_LOCAL) begin
        adc_data <= temp_base + step;
      end else begin
        adc_data <= volt_base + {3'h0, adc_channel} + step;
      end
    end
  end
endmodule : adc_sample_model

`default_nettype wire

// File: testbench/analog_monitor_sequencer_test.sv
// Self-checking bench for the analog monitoring sequencer
`timescale 1ns/1ps
`default_nettype none

module analog_monitor_sequencer_test;
  import monitor_pkg::*;
  localparam int TD = 4;
  logic core_clk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic [7:0] reg_rdata;
  logic [7:0] adc_data;
  logic [4:0] adc_channel;
  logic adc_start;
  logic busy;
  logic int_n;
  logic [7:0] temp_base;
  logic [7:0] volt_base;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int starts = 0;
  int seen;

  // Design with a short internal tick, and its converter
  analog_monitor_sequencer #(.TICK_DIVIDE(TD)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
    .adc_data(adc_data), .adc_channel(adc_channel), .adc_start(adc_start),
    .busy(busy), .int_n(int_n)
  );
  adc_sample_model far_end (
    .core_clk(core_clk), .reset_n(reset_n), .adc_channel(adc_channel),
    .adc_start(adc_start), .temp_base(temp_base), .volt_base(volt_base),
    .adc_data(adc_data)
  );

  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard and count of conversion starts
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    starts <= starts + int'(adc_start);
    if (cycles == 60000) begin
      errors++;
      $display("Error %0t: timeout", $time);
      give_verdict();
    end
  end

  // Expected reading: signed average of a ramp, or unsigned voltage ramp
  function automatic logic [7:0] slot_exp(input logic [4:0] ch);
    int s;
    s = 0;
    if (ch <= CH_REMOTE2 || ch == CH_LOCAL) begin
      for (int n = 0; n < 16; n++) begin
        s += int'($signed(8'(temp_base + 8'(n))));
      end
      return 8'(s >>> 4);
    end
    return volt_base + {3'h0, ch} + ((ch == CH_VBAT) ? 8'h00 : 8'h07);
  endfunction : slot_exp

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    idle(1);
    reg_write = 1'b0;
    idle(1);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr = a;
    idle(2);
    check(reg_rdata, exp, what);
  endtask : rd_check

  task automatic wait_chan(input logic [4:0] ch);
    int k;
    k = 0;
    while (adc_channel !== ch && k < 40000) begin
      idle(1);
      k++;
    end
    check({3'h0, adc_channel}, {3'h0, ch}, "channel reached");
  endtask : wait_chan

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    void'($urandom(80));
    temp_base = 8'hF8 - 8'($urandom % 8);
    volt_base = 8'($urandom % 192);
    idle(10);
    reset_n = 1'b1;
    check({5'h00, busy, adc_start, int_n}, 8'h01, "idle after reset");
    rd_check(ADDR_CONFIG, 8'h00, "config reset");
    rd_check(ADDR_HIGH_BASE + 8'h02, 8'hFF, "high limit reset");
    rd_check(ADDR_LOW_BASE + 8'h02, 8'h00, "low limit reset");
    wr(ADDR_LOCAL_TEMP, 8'h5A);
    rd_check(ADDR_LOCAL_TEMP, 8'h00, "value read only");
    rd_check(8'hFF, 8'h00, "unmapped read");
    wr(ADDR_CONFIG, 8'h05);
    idle(4);
    check({6'h00, busy, adc_start}, 8'h00, "start refused while clearing");
    $display("test register_map done");
    wr(ADDR_HIGH_BASE + 8'h02, slot_exp(5'h02) - 8'h01);
    wr(ADDR_LOW_BASE + 8'h03, slot_exp(5'h03) + 8'h01);
    wr(ADDR_HIGH_BASE + 8'h14, slot_exp(CH_LOCAL) - 8'h01);
    wr(ADDR_CONFIG, 8'h0B);
    wait_chan(CH_LOCAL);
    wait_chan(CH_REMOTE1);
    for (int ch = 0; ch < CH_COUNT; ch++) begin
      if (ch != 1) begin
        rd_check(ADDR_VALUE_BASE + 8'(ch), slot_exp(5'(ch)), "slot value");
      end
    end
    rd_check(ADDR_LOCAL_TEMP, slot_exp(CH_LOCAL), "local temperature");
    rd_check(ADDR_SHARED_PIN, slot_exp(CH_GENERAL_ANALOG_INPUT_EIGHT), "pair first input");
    rd_check(ADDR_SECOND_REMOTE, slot_exp(CH_GENERAL_ANALOG_INPUT_NINE), "pair second input");
    rd_check(ADDR_STATUS_BASE, 8'h0C, "low slot flags");
    rd_check(ADDR_STATUS_BASE + 8'h01, 8'h00, "middle slot flags");
    rd_check(ADDR_STATUS_BASE + 8'h02, 8'h10, "high slot flags");
    check({7'h00, int_n}, 8'h00, "interrupt asserted");
    $display("test analog_pair_pass done");
    wr(ADDR_CONFIG, 8'h09);
    idle(3);
    check({7'h00, int_n}, 8'h01, "interrupt masked");
    wr(ADDR_CONFIG, 8'h0D);
    rd_check(ADDR_STATUS_BASE, 8'h00, "flags cleared");
    wr(ADDR_CONFIG, 8'h01);
    wait_chan(CH_REMOTE2 + 5'h01);
    rd_check(ADDR_SECOND_REMOTE, slot_exp(CH_REMOTE2), "second remote");
    rd_check(ADDR_SHARED_PIN, slot_exp(CH_GENERAL_ANALOG_INPUT_EIGHT), "pair register kept");
    $display("test diode_pair done");
    wr(ADDR_CONFIG, 8'h00);
    idle(4);
    check({6'h00, busy, adc_start}, 8'h00, "stopped");
    seen = starts;
    idle(300);
    check(8'(starts - seen), 8'h00, "no conversions after stop");
    $display("test stop done");
    give_verdict();
  end
endmodule : analog_monitor_sequencer_test

`default_nettype wire
